/* File: core/uil_pkg.sv */
// Purpose: Shared constants and carriers for the UART summary/line-status block
// Assumes: Registers are 8 bits wide, one per aligned 32-bit Wishbone word
// Notes: Register byte address is four times the register index
package uil_pkg;
	// Register indices; byte address = index << IDX_SHIFT
	localparam int IDX_SHIFT = 2;
	localparam int IDX_W = 6;
	localparam logic [5:0] IDX_RECEIVE_HOLDING = 6'h00;
	localparam logic [5:0] IDX_PIN_IRQ_EN = 6'h01;
	localparam logic [5:0] IDX_SUMMARY = 6'h02;
	localparam logic [5:0] IDX_ROUTE_EN = 6'h03;
	localparam logic [5:0] IDX_LINE_STATUS = 6'h04;
	localparam logic [5:0] IDX_SECOND_MODE = 6'h09;
	localparam logic [5:0] IDX_THRESHOLD = 6'h0a;
	localparam logic [5:0] IDX_STALE_PERIOD = 6'h0b;
	localparam logic [5:0] IDX_LINE_CFG = 6'h0c;

	// Reset values
	localparam logic [7:0] SUMMARY_RST = 8'h60;
	localparam logic [7:0] THRESHOLD_RST = 8'hff;
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [7:0] ROUTE_MASK = 8'h3f;

	// Summary bit positions
	localparam int SUM_FLOW = 7;
	localparam int SUM_RX_EMPTY = 6;
	localparam int SUM_TX_EMPTY = 5;
	localparam int SUM_TX_LEVEL = 4;
	localparam int SUM_RX_LEVEL = 3;
	localparam int SUM_GEN_STATUS = 2;
	localparam int SUM_SPECIAL = 1;
	localparam int SUM_LINE_ERR = 0;

	// Line status bit positions
	localparam int LS_FLOW_LEVEL = 7;
	localparam int LS_OVERFLOW = 1;

	// Second mode setting bits
	localparam int M2_MULTIDROP = 6;
	localparam int M2_RX_EMPTY_INV = 3;
	localparam int M2_RX_LEVEL_INV = 2;

	// Line config bits
	localparam int CFG_PARITY_EN = 0;
	localparam int CFG_PARITY_ODD = 1;

	// Threshold fields: nibble times eight words
	localparam int TX_LVL_LSB = 0;
	localparam int RX_LVL_LSB = 4;
	localparam int LVL_W = 4;
	localparam int TRIG_SHIFT = 3;

	// Receive FIFO
	localparam int FIFO_DEPTH = 128;
	localparam int PTR_W = 7;
	localparam int CNT_W = 8;
	localparam logic [7:0] FIFO_FULL = 8'h80;
	localparam logic [7:0] FIFO_NONE = 8'h00;

	// Word handed over by the receiver
	typedef struct packed {
		logic [7:0] data;
		logic parity_bit;
		logic ninth;
		logic noise;
		logic stop_bad;
	} uil_rx_word_s;

	// Stored FIFO entry with its per-character tags
	typedef struct packed {
		logic [7:0] data;
		logic noise;
		logic brk;
		logic framing;
		logic parity;
	} uil_entry_s;
endpackage

/* File: core/uil_line_status_irq.sv */
// Purpose: Interrupt summary, line-status flags and receive FIFO of one UART
// Assumes: Receiver, TX FIFO and special-char logic share clk_i
// Notes: Registers reached over classic Wishbone, one ack per request
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns

// How it works
// - Reading the summary register clears every bit that was read unless its source sets it again.
// - Any level change on the flow-control input sets summary bit 7.
// - Summary bit 6 sets while receive FIFO empty, or not empty if inverted.
// - Summary bit 5 sets when the transmit FIFO becomes empty.
// - Summary bit 4 tracks transmit count at or above its trigger level.
// - Summary bit 3 sets at receive trigger level, optionally inverted.
// - Summary bit 2 sets while any enabled general status bit is high.
// - Summary bit 1 sets on the special character event input only.
// - Summary bit 0 sets when any routed line error flag becomes set.
// - Each line error reaches summary bit 0 only through its route enable.
// - Character tags (line status bits 5 to 2) describe the last popped word; read keeps them.
// - Line status bit 7 shows the live flow-control input level.
// - Noise seen during a character is stored and shown when popped.
// - A line break pushes an all-zero character tagged as break.
// - Bad stop bits tag the character with a framing error.
// - Parity mismatch tags the character with a parity error.
// - In multidrop mode bit 2 shows the ninth bit, parity unchecked.
// - A word arriving at a full FIFO is dropped and sets overflow.
// - Overflow clears on line status read or FIFO below full.
// - Stale flag sets when newest word waits past the set period.
// - Period zero disables the stale flag; push or pop clears it.
// - Tags of a character vanish once the next clean one is popped.
// - Interrupt pin asserts only for enabled summary bits.
// - Receive holding shows the oldest word; each read of a non-empty FIFO pops one.
module uil_line_status_irq (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Receiver side
	input wire logic rx_valid_i,
	input wire uil_pkg::uil_rx_word_s rx_word_i,
	input wire logic rx_break_i,
	input wire logic char_tick_i,
	// Other UART sources
	input wire logic flow_input_n_i,
	input wire logic [7:0] tx_count_i,
	input wire logic [7:0] general_status_i,
	input wire logic [7:0] general_status_enable_i,
	input wire logic special_char_event_i,
	// Interrupt pin
	output logic irq_n_o
);

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave

	logic req;
	logic ack_r;
	logic fire;
	logic rd_fire;
	logic wr_fire;
	logic [5:0] idx;
	logic [7:0] rd_mux;
	logic [7:0] dat_r;
	logic pop_ok_r;

	assign req = wb_cyc_i & wb_stb_i;
	assign idx = wb_adr_i[uil_pkg::IDX_SHIFT +: uil_pkg::IDX_W];
	// Side effects happen on the edge where the master sees ack
	assign fire = req & ack_r;
	assign rd_fire = fire & ~wb_we_i;
	assign wr_fire = fire & wb_we_i & wb_sel_i[0];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = {24'h000000, dat_r};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers

	logic [7:0] irq_en_r;
	logic [7:0] route_en_r;
	logic [7:0] second_mode_r;
	logic [7:0] thresh_r;
	logic [7:0] stale_period_r;
	logic [7:0] line_cfg_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_r <= uil_pkg::ZERO_RST;
			route_en_r <= uil_pkg::ZERO_RST;
			second_mode_r <= uil_pkg::ZERO_RST;
			thresh_r <= uil_pkg::THRESHOLD_RST;
			stale_period_r <= uil_pkg::ZERO_RST;
			line_cfg_r <= uil_pkg::ZERO_RST;
		end else if (wr_fire) begin
			if (idx == uil_pkg::IDX_PIN_IRQ_EN) begin
				irq_en_r <= wb_dat_i[7:0];
			end else if (idx == uil_pkg::IDX_ROUTE_EN) begin
				route_en_r <= wb_dat_i[7:0] & uil_pkg::ROUTE_MASK;
			end else if (idx == uil_pkg::IDX_SECOND_MODE) begin
				second_mode_r <= wb_dat_i[7:0];
			end else if (idx == uil_pkg::IDX_THRESHOLD) begin
				thresh_r <= wb_dat_i[7:0];
			end else if (idx == uil_pkg::IDX_STALE_PERIOD) begin
				stale_period_r <= wb_dat_i[7:0];
			end else if (idx == uil_pkg::IDX_LINE_CFG) begin
				line_cfg_r <= wb_dat_i[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flow-control input: two-stage synchroniser plus a history stage

	logic flow_s1_r;
	logic flow_s2_r;
	logic flow_s3_r;

	// No reset: the stages settle to the pin while reset is held (three
	// edges at least), so the history matches and no false edge follows
	always_ff @(posedge clk_i) begin
		flow_s1_r <= flow_input_n_i;
		flow_s2_r <= flow_s1_r;
		flow_s3_r <= flow_s2_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Receive FIFO with per-character tags

	uil_pkg::uil_entry_s mem [uil_pkg::FIFO_DEPTH];
	uil_pkg::uil_entry_s new_entry;
	uil_pkg::uil_entry_s head;
	logic [6:0] wr_ptr_r;
	logic [6:0] rd_ptr_r;
	logic [7:0] cnt_r;
	logic push_req;
	logic full;
	logic push;
	logic pop;
	logic par_exp;

	assign head = mem[rd_ptr_r];
	assign push_req = rx_valid_i | rx_break_i;
	assign full = (cnt_r == uil_pkg::FIFO_FULL);
	assign push = push_req & ~full;
	// Pop only if a word was presented when the read data was latched
	assign pop = rd_fire & pop_ok_r &
		(idx == uil_pkg::IDX_RECEIVE_HOLDING);
	assign par_exp = (^rx_word_i.data) ^ line_cfg_r[uil_pkg::CFG_PARITY_ODD];

	always_comb begin
		new_entry.data = rx_word_i.data;
		new_entry.noise = rx_word_i.noise;
		new_entry.brk = 1'b0;
		new_entry.framing = rx_word_i.stop_bad;
		if (second_mode_r[uil_pkg::M2_MULTIDROP]) begin
			new_entry.parity = rx_word_i.ninth;
		end else begin
			new_entry.parity = line_cfg_r[uil_pkg::CFG_PARITY_EN] &
				(par_exp != rx_word_i.parity_bit);
		end
		if (rx_break_i) begin
			new_entry = '0;
			new_entry.brk = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_r] <= new_entry;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= uil_pkg::FIFO_NONE;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 7'h01;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 7'h01;
			end
			cnt_r <= cnt_r + 8'(push) - 8'(pop);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line status flags

	logic [3:0] tags_r;
	logic ovf_r;
	logic stale_r;
	logic [7:0] tick_cnt_r;
	logic [7:0] line_status;
	logic [5:0] routed;
	logic [5:0] routed_d_r;

	// Tags follow the popped word, so a clean word wipes old ones
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tags_r <= '0;
		end else if (pop) begin
			tags_r <= {head.noise, head.brk, head.framing,
				head.parity};
		end
	end

	// A read clears overflow only if it was read as set; leaving full also clears it; set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovf_r <= 1'b0;
		end else begin
			ovf_r <= (ovf_r & ~(rd_fire & dat_r[uil_pkg::LS_OVERFLOW] &
				(idx == uil_pkg::IDX_LINE_STATUS)) & full) |
				(push_req & full);
		end
	end

	// Ticks are character times from the baud logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_r <= '0;
			stale_r <= 1'b0;
		end else begin
			if (push | pop) begin
				tick_cnt_r <= '0;
			end else if (char_tick_i && tick_cnt_r != stale_period_r) begin
				tick_cnt_r <= tick_cnt_r + 8'h01;
			end
			stale_r <= ~(push | pop) & (stale_period_r != 8'h00) &
				(cnt_r != uil_pkg::FIFO_NONE) &
				(tick_cnt_r >= stale_period_r);
		end
	end

	assign line_status = {flow_s2_r, 1'b0, tags_r, ovf_r, stale_r};
	assign routed = line_status[5:0] & route_en_r[5:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			routed_d_r <= '0;
		end else begin
			routed_d_r <= routed;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt summary

	logic [7:0] sum_r;
	logic [7:0] sum_set;
	logic [7:0] sum_clr;
	logic [7:0] tx_lvl;
	logic [7:0] rx_lvl;
	logic tx_above;
	logic tx_empty_d_r;
	logic irq_n_r;

	assign tx_lvl = 8'(thresh_r[uil_pkg::TX_LVL_LSB +: uil_pkg::LVL_W])
		<< uil_pkg::TRIG_SHIFT;
	assign rx_lvl = 8'(thresh_r[uil_pkg::RX_LVL_LSB +: uil_pkg::LVL_W])
		<< uil_pkg::TRIG_SHIFT;
	assign tx_above = (tx_count_i >= tx_lvl);

	always_comb begin
		sum_set = '0;
		sum_set[uil_pkg::SUM_FLOW] = flow_s2_r ^ flow_s3_r;
		sum_set[uil_pkg::SUM_RX_EMPTY] = (cnt_r == uil_pkg::FIFO_NONE) ^
			second_mode_r[uil_pkg::M2_RX_EMPTY_INV];
		sum_set[uil_pkg::SUM_TX_EMPTY] = (tx_count_i == uil_pkg::FIFO_NONE) &
			~tx_empty_d_r;
		sum_set[uil_pkg::SUM_TX_LEVEL] = tx_above;
		sum_set[uil_pkg::SUM_RX_LEVEL] = (cnt_r >= rx_lvl) ^
			second_mode_r[uil_pkg::M2_RX_LEVEL_INV];
		sum_set[uil_pkg::SUM_GEN_STATUS] =
			|(general_status_i & general_status_enable_i);
		sum_set[uil_pkg::SUM_SPECIAL] = special_char_event_i;
		sum_set[uil_pkg::SUM_LINE_ERR] = |(routed & ~routed_d_r);
		sum_clr = '0;
		if (rd_fire && idx == uil_pkg::IDX_SUMMARY) begin
			sum_clr = dat_r;
		end
		sum_clr[uil_pkg::SUM_TX_LEVEL] = sum_clr[uil_pkg::SUM_TX_LEVEL] |
			~tx_above;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sum_r <= uil_pkg::SUMMARY_RST;
			tx_empty_d_r <= 1'b1;
		end else begin
			sum_r <= (sum_r & ~sum_clr) | sum_set;
			tx_empty_d_r <= (tx_count_i == uil_pkg::FIFO_NONE);
		end
	end

	// Enables gate only the pin, never the summary contents
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_n_r <= 1'b1;
		end else begin
			irq_n_r <= ~|(sum_r & irq_en_r);
		end
	end

	assign irq_n_o = irq_n_r;

	////////////////////////////////////////////////////////////////////////
	// Read data, latched one cycle before ack so it is stable under it

	always_comb begin
		if (idx == uil_pkg::IDX_RECEIVE_HOLDING) begin
			rd_mux = (cnt_r != uil_pkg::FIFO_NONE) ? head.data : 8'h00;
		end else if (idx == uil_pkg::IDX_PIN_IRQ_EN) begin
			rd_mux = irq_en_r;
		end else if (idx == uil_pkg::IDX_SUMMARY) begin
			rd_mux = sum_r;
		end else if (idx == uil_pkg::IDX_ROUTE_EN) begin
			rd_mux = route_en_r;
		end else if (idx == uil_pkg::IDX_LINE_STATUS) begin
			rd_mux = line_status;
		end else if (idx == uil_pkg::IDX_SECOND_MODE) begin
			rd_mux = second_mode_r;
		end else if (idx == uil_pkg::IDX_THRESHOLD) begin
			rd_mux = thresh_r;
		end else if (idx == uil_pkg::IDX_STALE_PERIOD) begin
			rd_mux = stale_period_r;
		end else if (idx == uil_pkg::IDX_LINE_CFG) begin
			rd_mux = line_cfg_r;
		end else begin
			rd_mux = 8'h00;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 8'h00;
			pop_ok_r <= 1'b0;
		end else if (req && !ack_r) begin
			dat_r <= rd_mux;
			pop_ok_r <= (cnt_r != uil_pkg::FIFO_NONE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_sum_read_clears;
		rd_fire && idx == uil_pkg::IDX_SUMMARY
			|=> (sum_r & $past(dat_r) & ~$past(sum_set)) == 8'h00;
	endproperty
	a_sum_read_clears: assert property (p_sum_read_clears)
		else $error("summary read did not clear read bits");

	property p_flow_change;
		flow_s2_r != flow_s3_r |=> sum_r[uil_pkg::SUM_FLOW];
	endproperty
	a_flow_change: assert property (p_flow_change)
		else $error("flow input change not flagged");

	property p_rx_empty;
		((cnt_r == uil_pkg::FIFO_NONE) ^
			second_mode_r[uil_pkg::M2_RX_EMPTY_INV])
			|=> sum_r[uil_pkg::SUM_RX_EMPTY];
	endproperty
	a_rx_empty: assert property (p_rx_empty)
		else $error("receive empty summary not set");

	property p_tx_below;
		!tx_above |=> !sum_r[uil_pkg::SUM_TX_LEVEL];
	endproperty
	a_tx_below: assert property (p_tx_below)
		else $error("transmit level bit stays set below level");

	property p_line_err;
		|(routed & ~routed_d_r) |=> sum_r[uil_pkg::SUM_LINE_ERR];
	endproperty
	a_line_err: assert property (p_line_err)
		else $error("routed line error not summarised");

	property p_overflow;
		push_req && full && !pop |=> ovf_r && cnt_r == uil_pkg::FIFO_FULL;
	endproperty
	a_overflow: assert property (p_overflow)
		else $error("overflow not flagged or word stored");

	property p_stale_off;
		(stale_period_r == 8'h00) [*2] |-> !stale_r;
	endproperty
	a_stale_off: assert property (p_stale_off)
		else $error("stale flag set with zero period");

	property p_irq_pin;
		!(|(sum_r & irq_en_r)) |=> irq_n_o;
	endproperty
	a_irq_pin: assert property (p_irq_pin)
		else $error("interrupt pin asserted without enabled bit");

	property p_irq_drive;
		|(sum_r & irq_en_r) |=> !irq_n_o;
	endproperty
	a_irq_drive: assert property (p_irq_drive)
		else $error("interrupt pin idle with enabled bit set");

	property p_pop_tags;
		pop |=> tags_r == {$past(head.noise), $past(head.brk),
			$past(head.framing), $past(head.parity)};
	endproperty
	a_pop_tags: assert property (p_pop_tags)
		else $error("line tags do not follow popped word");

	c_overflow: cover property (push_req && full);
	c_stale: cover property ($rose(stale_r));
	c_sum_read: cover property (rd_fire && idx == uil_pkg::IDX_SUMMARY);
	c_break: cover property (push && rx_break_i);

endmodule

/* File: tb/uil_host_model.sv */
// Purpose: Wishbone classic master standing in for the host controller
// Assumes: One request at a time; the slave acks every request
// Notes: Waits on ack without limit; the bench watchdog cuts a hang short
`timescale 1ns/1ns
module uil_host_model (
	// Clock
	input wire logic clk_i,
	// Wishbone master
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_i
);
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h00000000;
	end

	////////////////////////////////////////////////////////////////////////
	// Entry waits one edge first, so cyc stays low a cycle between requests
	task automatic xfer(input logic we, input logic [5:0] idx,
		input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= {idx, 2'b00};
		wb_sel_o <= 4'h1;
		wb_dat_o <= {24'h000000, wd};
		do @(posedge clk_i); while (wb_ack_i !== 1'b1);
		rd = wb_dat_i[7:0];
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		// Released data no longer shows the last value
		wb_dat_o <= ~{24'h000000, wd};
	endtask
endmodule

/* File: tb/uil_line_status_irq_bench.sv */
// Purpose: Self-checking bench for the summary and line-status block
// Assumes: Host model issues one Wishbone request at a time
// Notes: Expected values come from the register map and the flag rules
`timescale 1ns/1ns
module uil_line_status_irq_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic rx_valid_i = 1'b0;
	logic rx_break_i = 1'b0;
	logic char_tick_i = 1'b0;
	logic flow_input_n_i = 1'b1;
	logic special_char_event_i = 1'b0;
	logic [7:0] tx_count_i = 8'h00;
	logic [7:0] general_status_i = 8'h00;
	logic [7:0] general_status_enable_i = 8'h00;
	uil_pkg::uil_rx_word_s rx_word_i = '0;
	logic wb_cyc, wb_stb, wb_we, wb_ack, irq_n_o;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_wd, wb_rd;
	logic [7:0] route = 8'h3f;
	int failures = 0;
	int checks = 0;

	always #2 clk_i = ~clk_i;

	uil_host_model host_u (.clk_i(clk_i), .wb_cyc_o(wb_cyc),
		.wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
		.wb_sel_o(wb_sel), .wb_dat_o(wb_wd), .wb_dat_i(wb_rd),
		.wb_ack_i(wb_ack));

	uil_line_status_irq dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd),
		.wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .rx_valid_i(rx_valid_i),
		.rx_word_i(rx_word_i), .rx_break_i(rx_break_i),
		.char_tick_i(char_tick_i), .flow_input_n_i(flow_input_n_i),
		.tx_count_i(tx_count_i), .general_status_i(general_status_i),
		.general_status_enable_i(general_status_enable_i),
		.special_char_event_i(special_char_event_i), .irq_n_o(irq_n_o));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] unused;
		host_u.xfer(1'b1, idx, d, unused);
	endtask
	task automatic rdc(input logic [5:0] idx, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] d;
		host_u.xfer(1'b0, idx, 8'h00, d);
		chk(d & m, e);
	endtask
	task automatic sm(input logic [7:0] m, input logic [7:0] e);
		rdc(uil_pkg::IDX_SUMMARY, m, e);
	endtask
	task automatic ls(input logic [7:0] m, input logic [7:0] e);
		rdc(uil_pkg::IDX_LINE_STATUS, m, e);
	endtask
	// Flags nibble is parity bit, ninth bit, noise, bad stop
	task automatic push(input logic [7:0] d, input logic [3:0] f);
		@(posedge clk_i);
		rx_valid_i <= 1'b1;
		rx_word_i <= {d, f};
		@(posedge clk_i);
		rx_valid_i <= 1'b0;
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_i);
			char_tick_i <= 1'b1;
			@(posedge clk_i);
			char_tick_i <= 1'b0;
		end
		cyc(2);
	endtask
	task automatic popc(input logic [7:0] d, input logic [7:0] e);
		rdc(uil_pkg::IDX_RECEIVE_HOLDING, 8'hff, d);
		ls(8'hff, e);
		ls(8'hff, e);
		sm(8'h01, {7'h00, |(e[5:0] & route[5:0])});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(20000);
		failures++;
		end_of_test();
	end

	initial begin
		cyc(6);
		rst_i <= 1'b0;
		sm(8'hff, 8'h60);
		sm(8'hff, 8'h40);
		ls(8'hff, 8'h80);
		rdc(uil_pkg::IDX_ROUTE_EN, 8'hff, 8'h00);
		rdc(6'h3f, 8'hff, 8'h00);
		wr(uil_pkg::IDX_ROUTE_EN, 8'hff);
		rdc(uil_pkg::IDX_ROUTE_EN, 8'hff, 8'h3f);
		done("registers");
		flow_input_n_i <= 1'b0;
		cyc(5);
		sm(8'h80, 8'h80);
		ls(8'h80, 8'h00);
		sm(8'h80, 8'h00);
		tx_count_i <= 8'h05;
		cyc(2);
		tx_count_i <= 8'h00;
		cyc(3);
		sm(8'h20, 8'h20);
		wr(uil_pkg::IDX_THRESHOLD, 8'h01);
		tx_count_i <= 8'h08;
		cyc(3);
		tx_count_i <= 8'h07;
		cyc(3);
		sm(8'h18, 8'h08);
		tx_count_i <= 8'h08;
		cyc(3);
		sm(8'h10, 8'h10);
		wr(uil_pkg::IDX_SECOND_MODE, 8'h0c);
		sm(8'h48, 8'h48);
		sm(8'h48, 8'h00);
		wr(uil_pkg::IDX_SECOND_MODE, 8'h00);
		general_status_i <= 8'h01;
		cyc(3);
		sm(8'h04, 8'h00);
		general_status_enable_i <= 8'h01;
		cyc(3);
		sm(8'h04, 8'h04);
		general_status_i <= 8'h00;
		sm(8'h04, 8'h04);
		done("summary sources");
		@(posedge clk_i);
		special_char_event_i <= 1'b1;
		@(posedge clk_i);
		special_char_event_i <= 1'b0;
		cyc(4);
		chk({7'h00, irq_n_o}, 8'h01);
		wr(uil_pkg::IDX_PIN_IRQ_EN, 8'h02);
		cyc(3);
		chk({7'h00, irq_n_o}, 8'h00);
		sm(8'h02, 8'h02);
		cyc(3);
		chk({7'h00, irq_n_o}, 8'h01);
		done("interrupt pin");
		// Even parity: every data byte below has an even count of ones
		wr(uil_pkg::IDX_LINE_CFG, 8'h01);
		push(8'ha5, 4'h2);
		push(8'h3c, 4'h8);
		@(posedge clk_i);
		rx_break_i <= 1'b1;
		@(posedge clk_i);
		rx_break_i <= 1'b0;
		push(8'h11, 4'h1);
		push(8'h22, 4'h0);
		sm(8'h01, 8'h00);
		popc(8'ha5, 8'h20);
		popc(8'h3c, 8'h04);
		popc(8'h00, 8'h10);
		popc(8'h11, 8'h08);
		popc(8'h22, 8'h00);
		wr(uil_pkg::IDX_SECOND_MODE, 8'h40);
		route = 8'h3b;
		wr(uil_pkg::IDX_ROUTE_EN, route);
		push(8'h55, 4'hc);
		push(8'h66, 4'h8);
		popc(8'h55, 8'h04);
		popc(8'h66, 8'h00);
		wr(uil_pkg::IDX_SECOND_MODE, 8'h00);
		wr(uil_pkg::IDX_LINE_CFG, 8'h00);
		done("receive tags");
		for (int i = 0; i < 129; i++)
			push(8'(i), 4'h0);
		ls(8'h02, 8'h02);
		ls(8'h02, 8'h00);
		for (int i = 0; i < 128; i++)
			rdc(uil_pkg::IDX_RECEIVE_HOLDING, 8'hff, 8'(i));
		sm(8'h40, 8'h40);
		done("overflow");
		wr(uil_pkg::IDX_STALE_PERIOD, 8'h02);
		push(8'h77, 4'h0);
		tick(2);
		ls(8'h01, 8'h01);
		push(8'h78, 4'h0);
		tick(1);
		ls(8'h01, 8'h00);
		tick(1);
		ls(8'h01, 8'h01);
		rdc(uil_pkg::IDX_RECEIVE_HOLDING, 8'hff, 8'h77);
		ls(8'h01, 8'h00);
		wr(uil_pkg::IDX_STALE_PERIOD, 8'h00);
		tick(3);
		ls(8'h01, 8'h00);
		done("stale data");
		end_of_test();
	end
endmodule
